// ---- rtl/pcm_top.sv ----
// pixel conversion, line mirror and exposure timing with an axi4-lite slave
// assumes sensor pixels arrive on aclk in 640-pixel lines, first marked sof
`include "pcm_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module pcm_top
  import pcm_pkg::*;
#(
  parameter int LINE_LEN = `PCM_LINE_LEN,
  parameter int FIFO_DEPTH = `PCM_FIFO_DEPTH,
  parameter int CLK_MHZ = `PCM_CLK_MHZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic [9:0] pix_data,
  input wire logic pix_sof,
  output logic vid_valid,
  input wire logic vid_ready,
  output logic [7:0] vid_data,
  output logic vid_sof,
  output logic vid_eol,
  output logic frame_start,
  output logic exposing
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = strb[i] ? wd[8*i +: 8] : old[8*i +: 8];
    end
    merge = old;
  endfunction

  // the product chain stays below 2^27, so no intermediate clipping
  function automatic logic [7:0] map_pix(input logic [9:0] s, input logic [7:0] g,
                                         input logic [9:0] b);
    logic signed [11:0] adj;
    logic [9:0] a;
    logic [18:0] p1;
    logic [26:0] p2;
    logic [10:0] q;
    adj = $signed({2'b00, s}) + $signed({2'b00, b}) - `PCM_BRIGHT_MID;
    a = (adj < 0) ? 10'd0 : ((adj > 12'sd1023) ? 10'd1023 : adj[9:0]);
    p1 = 19'(a) * 19'(`PCM_GAIN_BASE + 9'(g));
    p2 = 27'(p1) * 27'(`PCM_RECIP);
    q = p2[26:`PCM_RECIP_SHIFT];
    map_pix = (q > 11'd255) ? 8'hff : q[7:0];
  endfunction

  function automatic logic [19:0] clamp_exp(input logic [19:0] v);
    clamp_exp = (v < `PCM_EXP_MIN_US) ? `PCM_EXP_MIN_US :
                ((v > `PCM_EXP_MAX_US) ? `PCM_EXP_MAX_US : v);
  endfunction

  // ****************************************************************
  // register bus
  // ****************************************************************
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d, wdata_q, wdata_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic [7:0] gain_q, gain_d;
  logic [9:0] bright_q, bright_d;
  logic [19:0] exp_q, exp_d, frame_q, frame_d;
  logic lut_we;
  logic [9:0] lut_widx;
  logic [7:0] lut_wval;
  logic [31:0] wr_word;
  logic [1:0] act_ctrl_q;
  logic [19:0] period_q;
  logic [31:0] fcount_q;
  logic started_q;

  logic [7:0] lut [0:1023];

  always_comb begin
    awready_d = awready_q;
    wready_d = wready_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    ctrl_d = ctrl_q;
    gain_d = gain_q;
    bright_d = bright_q;
    exp_d = exp_q;
    frame_d = frame_q;
    lut_we = 1'b0;
    wr_word = 32'h0000_0000;
    if (s_axi_awvalid && awready_q) begin
      awaddr_d = s_axi_awaddr;
      awready_d = 1'b0;
    end
    if (s_axi_wvalid && wready_q) begin
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
      wready_d = 1'b0;
    end
    if (!awready_q && !wready_q && !bvalid_q) begin
      bvalid_d = 1'b1;
      bresp_d = PCM_RESP_OKAY;
      case (awaddr_q)
        `PCM_REG_CTRL: begin
          wr_word = merge({30'h0, ctrl_q}, wdata_q, wstrb_q);
          ctrl_d = wr_word[1:0];
        end
        `PCM_REG_GAIN: begin
          wr_word = merge({24'h0, gain_q}, wdata_q, wstrb_q);
          gain_d = wr_word[7:0];
        end
        `PCM_REG_BRIGHT: begin
          wr_word = merge({22'h0, bright_q}, wdata_q, wstrb_q);
          bright_d = wr_word[9:0];
        end
        `PCM_REG_EXPOSURE: begin
          wr_word = merge({12'h0, exp_q}, wdata_q, wstrb_q);
          exp_d = (wr_word[31:20] != 12'h000) ? `PCM_EXP_MAX_US : clamp_exp(wr_word[19:0]);
        end
        `PCM_REG_FRAME: begin
          wr_word = merge({12'h0, frame_q}, wdata_q, wstrb_q);
          frame_d = (wr_word[19:0] == 20'h0) ? 20'h1 : wr_word[19:0];
        end
        `PCM_REG_LUT_WR: begin
          // one write loads one pair; a full table takes 1024 writes
          lut_we = (wstrb_q == 4'hf);
        end
        `PCM_REG_STATUS, `PCM_REG_PERIOD, `PCM_REG_FCOUNT: begin
          bresp_d = PCM_RESP_OKAY;
        end
        default: begin
          bresp_d = PCM_RESP_SLVERR;
        end
      endcase
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
      awready_d = 1'b1;
      wready_d = 1'b1;
    end
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = PCM_RESP_OKAY;
      case (s_axi_araddr)
        `PCM_REG_CTRL: rdata_d = {30'h0, ctrl_q};
        `PCM_REG_GAIN: rdata_d = {24'h0, gain_q};
        `PCM_REG_BRIGHT: rdata_d = {22'h0, bright_q};
        `PCM_REG_EXPOSURE: rdata_d = {12'h0, exp_q};
        `PCM_REG_FRAME: rdata_d = {12'h0, frame_q};
        `PCM_REG_LUT_WR: rdata_d = 32'h0000_0000;
        `PCM_REG_STATUS: rdata_d = {30'h0, act_ctrl_q};
        `PCM_REG_PERIOD: rdata_d = {12'h0, period_q};
        `PCM_REG_FCOUNT: rdata_d = fcount_q;
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = PCM_RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
  end

  assign lut_widx = wdata_q[`PCM_LUT_IDX_HI:`PCM_LUT_IDX_LO];
  assign lut_wval = wdata_q[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= PCM_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= PCM_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      ctrl_q <= 2'b00;
      gain_q <= `PCM_GAIN_RST;
      bright_q <= `PCM_BRIGHT_RST;
      exp_q <= `PCM_EXPOSURE_RST;
      frame_q <= `PCM_FRAME_RST;
    end else begin
      // readies rise one edge after reset release
      awready_q <= awready_d || !started_q;
      wready_q <= wready_d || !started_q;
      bvalid_q <= bvalid_d && started_q;
      bresp_q <= bresp_d;
      arready_q <= arready_d || !started_q;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      ctrl_q <= ctrl_d;
      gain_q <= gain_d;
      bright_q <= bright_d;
      exp_q <= exp_d;
      frame_q <= frame_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (lut_we && started_q) begin
      lut[lut_widx] <= lut_wval;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // ****************************************************************
  // pixel path
  // ****************************************************************
  logic f_valid, f_sof, m_ready, take;
  logic [9:0] f_pix;
  logic [10:0] f_data;
  logic st_valid_q, st_valid_d, st_sof_q, st_sof_d, st_mir_q, st_mir_d;
  logic [7:0] st_pix_q, st_pix_d;
  logic [1:0] act_ctrl_d;
  logic [7:0] act_gain_q, act_gain_d;
  logic [9:0] act_bright_q, act_bright_d;
  logic [1:0] use_ctrl;
  logic [7:0] use_gain;
  logic [9:0] use_bright;
  logic [31:0] fcount_d;

  pcm_fifo #(.WIDTH(11), .DEPTH(FIFO_DEPTH)) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(pix_valid),
    .in_ready(pix_ready),
    .in_data({pix_sof, pix_data}),
    .out_valid(f_valid),
    .out_ready(take),
    .out_data(f_data)
  );

  assign f_pix = f_data[9:0];
  assign f_sof = f_data[10];
  assign take = f_valid && (!st_valid_q || m_ready);

  always_comb begin
    // the first pixel of a frame already sees the new settings
    use_ctrl = (take && f_sof) ? ctrl_q : act_ctrl_q;
    use_gain = (take && f_sof) ? gain_q : act_gain_q;
    use_bright = (take && f_sof) ? bright_q : act_bright_q;
    act_ctrl_d = use_ctrl;
    act_gain_d = use_gain;
    act_bright_d = use_bright;
    fcount_d = fcount_q + ((take && f_sof) ? 32'h1 : 32'h0);
    st_valid_d = st_valid_q;
    st_sof_d = st_sof_q;
    st_mir_d = st_mir_q;
    st_pix_d = st_pix_q;
    if (st_valid_q && m_ready) begin
      st_valid_d = 1'b0;
    end
    if (take) begin
      st_valid_d = 1'b1;
      st_sof_d = f_sof;
      st_mir_d = use_ctrl[`PCM_CTRL_MIRROR];
      st_pix_d = use_ctrl[`PCM_CTRL_LUT] ? lut[f_pix] :
                 map_pix(f_pix, use_gain, use_bright);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_ctrl_q <= 2'b00;
      act_gain_q <= `PCM_GAIN_RST;
      act_bright_q <= `PCM_BRIGHT_RST;
      fcount_q <= 32'h0000_0000;
      st_valid_q <= 1'b0;
      st_sof_q <= 1'b0;
      st_mir_q <= 1'b0;
      st_pix_q <= 8'h00;
    end else begin
      act_ctrl_q <= act_ctrl_d;
      act_gain_q <= act_gain_d;
      act_bright_q <= act_bright_d;
      fcount_q <= fcount_d;
      st_valid_q <= st_valid_d;
      st_sof_q <= st_sof_d;
      st_mir_q <= st_mir_d;
      st_pix_q <= st_pix_d;
    end
  end

  pcm_line_mirror #(.LINE_LEN(LINE_LEN)) u_mirror (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(st_valid_q),
    .in_ready(m_ready),
    .in_data(st_pix_q),
    .in_sof(st_sof_q),
    .in_mirror(st_mir_q),
    .out_valid(vid_valid),
    .out_ready(vid_ready),
    .out_data(vid_data),
    .out_sof(vid_sof),
    .out_eol(vid_eol)
  );

  // ****************************************************************
  // exposure and frame timer
  // ****************************************************************
  localparam logic [7:0] US_LAST = 8'(CLK_MHZ - 1);
  logic [7:0] pre_q, pre_d;
  logic [19:0] us_q, us_d, period_d;
  logic fs_q, fs_d, ex_q, ex_d;

  always_comb begin
    period_d = (exp_q > frame_q) ? exp_q : frame_q;
    pre_d = (pre_q == US_LAST) ? 8'h00 : pre_q + 8'h01;
    us_d = us_q;
    fs_d = 1'b0;
    if (pre_q == US_LAST) begin
      us_d = us_q + 20'h1;
      if (us_q + 20'h1 >= period_q) begin
        us_d = 20'h0;
        fs_d = 1'b1;
      end
    end
    ex_d = (us_d < exp_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 8'h00;
      us_q <= 20'h0;
      period_q <= `PCM_FRAME_RST;
      fs_q <= 1'b0;
      ex_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      us_q <= us_d;
      period_q <= period_d;
      fs_q <= fs_d;
      ex_q <= ex_d;
    end
  end

  assign frame_start = fs_q;
  assign exposing = ex_q;
endmodule
`default_nettype wire

// ---- shared/pcm_defs.svh ----
// constants for the pixel convert, mirror and exposure block
// assumes inclusion by bare name from the top rtl file only
// ****************************************************************
// ****************************************************************
`ifndef PCM_DEFS_SVH
`define PCM_DEFS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define PCM_REG_CTRL 8'h00
`define PCM_REG_GAIN 8'h04
`define PCM_REG_BRIGHT 8'h08
`define PCM_REG_EXPOSURE 8'h0c
`define PCM_REG_FRAME 8'h10
`define PCM_REG_LUT_WR 8'h14
`define PCM_REG_STATUS 8'h18
`define PCM_REG_PERIOD 8'h1c
`define PCM_REG_FCOUNT 8'h20

// ****************************************************************
// field positions
// ****************************************************************
`define PCM_CTRL_MIRROR 0
`define PCM_CTRL_LUT 1
`define PCM_LUT_IDX_LO 16
`define PCM_LUT_IDX_HI 25

// ****************************************************************
// reset values
// ****************************************************************
`define PCM_GAIN_RST 8'h00
`define PCM_BRIGHT_RST 10'd725
`define PCM_EXPOSURE_RST 20'd1000
`define PCM_FRAME_RST 20'd33333

// ****************************************************************
// mapping and timing
// ****************************************************************
`define PCM_BRIGHT_MID 12'sd725
`define PCM_GAIN_BASE 9'd85
`define PCM_RECIP 8'd193
`define PCM_RECIP_SHIFT 16
`define PCM_CLK_MHZ 125
`define PCM_EXP_MIN_US 20'd20
`define PCM_EXP_MAX_US 20'd81900
`define PCM_LINE_LEN 640
`define PCM_FIFO_DEPTH 8

`endif

// ---- shared/pcm_pkg.sv ----
// types for the pixel convert, mirror and exposure block
// assumes nothing beyond the constants header
package pcm_pkg;
  typedef enum logic [1:0] {
    PCM_RESP_OKAY = 2'b00,
    PCM_RESP_SLVERR = 2'b10
  } pcm_resp_t;
endpackage

// ---- rtl/pcm_fifo.sv ----
// small synchronous fifo with valid and ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module pcm_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic in_ready_q, in_ready_d, out_valid_q, out_valid_d;
  logic push, pop;

  assign push = in_valid && in_ready_q;
  assign pop = out_valid_q && out_ready;
  assign in_ready = in_ready_q;
  assign out_valid = out_valid_q;
  assign out_data = mem[rd_q];

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == LAST) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == LAST) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
    // registered flags keep in_ready and out_valid straight from flops
    in_ready_d = (cnt_d != FULL);
    out_valid_d = (cnt_d != '0);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready_q <= 1'b0;
      out_valid_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      in_ready_q <= in_ready_d;
      out_valid_q <= out_valid_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/pcm_line_mirror.sv ----
// two-bank line buffer: fills one line while the other drains
// assumes lines of exactly LINE_LEN pixels, first pixel of frame marked
`timescale 1ns/100ps
`default_nettype none
module pcm_line_mirror #(
  parameter int LINE_LEN = 640
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [7:0] in_data,
  input wire logic in_sof,
  input wire logic in_mirror,
  output logic out_valid,
  input wire logic out_ready,
  output logic [7:0] out_data,
  output logic out_sof,
  output logic out_eol
);
  localparam int CW = $clog2(LINE_LEN);
  localparam int AW = $clog2(2 * LINE_LEN);
  localparam logic [CW-1:0] LAST = CW'(LINE_LEN - 1);

  // both modes pay the same one-line latency so timing does not jump
  logic [7:0] mem [0:2*LINE_LEN-1];
  logic [CW-1:0] wcnt_q, wcnt_d, rcnt_q, rcnt_d;
  logic wbank_q, wbank_d, rbank_q, rbank_d;
  logic [1:0] full_q, full_d, mir_q, mir_d, sof_q, sof_d;
  logic ov_q, ov_d, os_q, os_d, oe_q, oe_d;
  logic [7:0] od_q, od_d;
  logic push, adv;
  logic [CW-1:0] ridx;

  function automatic logic [AW-1:0] addr(input logic bank, input logic [CW-1:0] idx);
    addr = AW'(bank ? LINE_LEN : 0) + AW'(idx);
  endfunction

  assign in_ready = !full_q[wbank_q];
  assign push = in_valid && in_ready;
  assign adv = !ov_q || out_ready;
  assign ridx = mir_q[rbank_q] ? LAST - rcnt_q : rcnt_q;
  assign out_valid = ov_q;
  assign out_data = od_q;
  assign out_sof = os_q;
  assign out_eol = oe_q;

  always_comb begin
    wcnt_d = wcnt_q;
    wbank_d = wbank_q;
    rcnt_d = rcnt_q;
    rbank_d = rbank_q;
    full_d = full_q;
    mir_d = mir_q;
    sof_d = sof_q;
    ov_d = ov_q;
    os_d = os_q;
    oe_d = oe_q;
    od_d = od_q;
    if (adv) begin
      ov_d = 1'b0;
      if (full_q[rbank_q]) begin
        ov_d = 1'b1;
        od_d = mem[addr(rbank_q, ridx)];
        os_d = sof_q[rbank_q] && (rcnt_q == '0);
        oe_d = (rcnt_q == LAST);
        rcnt_d = rcnt_q + 1'b1;
        if (rcnt_q == LAST) begin
          rcnt_d = '0;
          full_d[rbank_q] = 1'b0;
          rbank_d = !rbank_q;
        end
      end
    end
    if (push) begin
      if (wcnt_q == '0) begin
        mir_d[wbank_q] = in_mirror;
        sof_d[wbank_q] = in_sof;
      end
      wcnt_d = wcnt_q + 1'b1;
      if (wcnt_q == LAST) begin
        wcnt_d = '0;
        full_d[wbank_q] = 1'b1;
        wbank_d = !wbank_q;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wcnt_q <= '0;
      wbank_q <= 1'b0;
      rcnt_q <= '0;
      rbank_q <= 1'b0;
      full_q <= '0;
      mir_q <= '0;
      sof_q <= '0;
      ov_q <= 1'b0;
      os_q <= 1'b0;
      oe_q <= 1'b0;
      od_q <= 8'h00;
    end else begin
      wcnt_q <= wcnt_d;
      wbank_q <= wbank_d;
      rcnt_q <= rcnt_d;
      rbank_q <= rbank_d;
      full_q <= full_d;
      mir_q <= mir_d;
      sof_q <= sof_d;
      ov_q <= ov_d;
      os_q <= os_d;
      oe_q <= oe_d;
      od_q <= od_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[addr(wbank_q, wcnt_q)] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/pcm_top_fix_note.sv ----
// (intentionally empty)

// ---- tb/pcm_checker.sv ----
// checker on the ports of pcm_top
// assumes one clock and a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module pcm_checker #(
  parameter int LINE_LEN = 640
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic vid_valid,
  input wire logic vid_ready,
  input wire logic [7:0] vid_data,
  input wire logic vid_sof,
  input wire logic vid_eol,
  input wire logic frame_start
);
  // ****************
  // position in outgoing line
  // ****************
  int pos_q;
  int pos_d;
  always_comb begin
    pos_d = pos_q;
    if (vid_valid && vid_ready) pos_d = vid_eol ? 0 : pos_q + 1;
  end
  always_ff @(posedge aclk) begin
    pos_q <= aresetn ? pos_d : 0;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while response pending");
  video_hold_a: assert property (vid_valid && !vid_ready |=>
    vid_valid && $stable({vid_data, vid_sof, vid_eol}))
    else $error("video pixel not held under stall");
  line_end_a: assert property (vid_valid |-> vid_eol == (pos_q == LINE_LEN - 1))
    else $error("line end flag at wrong pixel");
  frame_first_a: assert property (vid_valid && vid_sof |-> pos_q == 0)
    else $error("frame start flag inside a line");
  frame_pulse_a: assert property (frame_start |=> !frame_start)
    else $error("frame start longer than one cycle");
endmodule
`default_nettype wire

// ---- tb/pcm_sensor_model.sv ----
// partner: sensor readout feeding pixels, transmit path taking video
// assumes go pulses one cycle per frame of two lines
`timescale 1ns/100ps
`default_nettype none
module pcm_sensor_model #(
  parameter int LINE_LEN = 640
) (
  input wire logic aclk,
  input wire logic go,
  input wire logic pix_ready,
  output logic pix_valid,
  output logic [9:0] pix_data,
  output logic pix_sof,
  output logic vid_ready
);
  int n = 2 * LINE_LEN;
  int cyc = 0;
  initial begin
    pix_valid = 0;
    pix_data = 0;
    pix_sof = 0;
    vid_ready = 0;
  end
  // long output stalls back the stream up; idle data toggles so it is never trusted
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    vid_ready <= cyc % 64 >= 40;
    if (go) n = 0;
    else if (pix_valid && pix_ready) n = n + 1;
    if (!pix_valid || pix_ready) begin
      pix_valid <= n < 2 * LINE_LEN && cyc % 7 != 3;
      pix_sof <= n == 0;
      pix_data <= n < 2 * LINE_LEN ? 10'(n * 37) : ~pix_data;
    end
  end
endmodule
`default_nettype wire

// ---- tb/test_pcm_top.sv ----
// self-checking bench for pcm_top
// assumes the sensor model and checker alongside
`timescale 1ns/100ps
`default_nettype none
module test_pcm_top;
  import pcm_pkg::*;
  localparam int L = 640;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pix_valid;
  logic pix_ready, pix_sof, vid_valid, vid_ready, vid_sof, vid_eol, frame_start, exposing, go;
  logic [7:0] s_axi_awaddr, s_axi_araddr, vid_data;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, wresp;
  logic [9:0] pix_data;
  logic [8:0] got[$];
  int err_count = 0;
  int compares = 0;
  pcm_top #(.LINE_LEN(L)) dut (.*);
  pcm_sensor_model #(.LINE_LEN(L)) model (.aclk(aclk), .go(go), .pix_ready(pix_ready),
    .pix_valid(pix_valid), .pix_data(pix_data), .pix_sof(pix_sof), .vid_ready(vid_ready));
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    if (vid_valid && vid_ready) got.push_back({vid_sof, vid_data});
  end
  // ****************
  // checks and bus cycles
  // ****************
  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    logic aw, w, b;
    t = 0;
    b = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!b && t < 100) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      wresp = s_axi_bresp;
      @(posedge aclk);
      t++;
      if (aw) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
    end
    check("write", b, 1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int t;
    logic ar, v;
    logic [33:0] s;
    t = 0;
    v = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!v && t < 100) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      s = {s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      t++;
      if (ar) s_axi_arvalid <= 0;
    end
    check("read", v ? s : 'x, {er, e});
  endtask
  function automatic logic [7:0] pix_exp(int s, int g, int b, logic lut);
    int a;
    a = s + b - 725;
    a = a < 0 ? 0 : (a > 1023 ? 1023 : a);
    a = (a * (85 + g) * 193) >> 16;
    return lut ? 8'(s * 3) : (a > 255 ? 8'hff : 8'(a));
  endfunction
  // settings land at the frame's first pixel, so each frame is set up before it starts
  task automatic frame(input logic [1:0] c, input logic [7:0] g, input logic [9:0] b);
    int k;
    int t;
    wr(8'h00, {30'h0, c});
    wr(8'h04, {24'h0, g});
    wr(8'h08, {22'h0, b});
    got.delete();
    go <= 1;
    @(posedge aclk);
    go <= 0;
    t = 0;
    while (got.size() < 2 * L && t < 20000) begin
      @(posedge aclk);
      t++;
      if (t == 99) wr(8'h04, {24'h0, ~g});
    end
    for (int j = 0; j < 2 * L; j++) begin
      k = (j / L) * L + (c[0] ? L - 1 - j % L : j % L);
      check("pixel", got[j], {j == 0, pix_exp((k * 37) % 1024, g, b, c[1])});
    end
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic s_defaults();
    rd(8'h00, 0, PCM_RESP_OKAY);
    rd(8'h04, 0, PCM_RESP_OKAY);
    rd(8'h08, 725, PCM_RESP_OKAY);
    rd(8'h24, 0, PCM_RESP_SLVERR);
    wr(8'h24, 1);
    check("bresp", wresp, PCM_RESP_SLVERR);
    frame(2'b00, 8'h00, 10'd725);
  endtask
  task automatic s_mirror();
    frame(2'b01, 8'h55, 10'd800);
    frame(2'b01, 8'hff, 10'd600);
  endtask
  task automatic s_lut();
    for (int i = 0; i < 1024; i++) wr(8'h14, {6'h0, 10'(i), 8'h0, 8'(i * 3)});
    frame(2'b11, 8'hff, 10'd100);
    rd(8'h14, 0, PCM_RESP_OKAY);
    rd(8'h18, 3, PCM_RESP_OKAY);
  endtask
  task automatic s_exposure();
    wr(8'h0c, 5);
    rd(8'h0c, 20, PCM_RESP_OKAY);
    wr(8'h0c, 99999);
    rd(8'h0c, 81900, PCM_RESP_OKAY);
    wr(8'h0c, 40000);
    rd(8'h1c, 40000, PCM_RESP_OKAY);
  endtask
  // frame 40us and exposure 20us: one period is 5000 cycles, half of them exposing
  task automatic s_timer();
    int n;
    int x;
    wr(8'h10, 40);
    wr(8'h0c, 20);
    n = 0;
    x = 0;
    while (!frame_start && n < 6000) begin
      @(negedge aclk);
      n++;
    end
    n = 0;
    do begin
      @(negedge aclk);
      n++;
      x += exposing;
    end while (!frame_start && n < 6000);
    check("period", n, 5000);
    check("exposing", x, 2500);
    @(posedge aclk);
    rd(8'h20, 4, PCM_RESP_OKAY);
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge aclk);
    err_count++;
    wrap_up();
  end
  initial begin
    {aclk, aresetn, go, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
    s_axi_rready = 0;
    s_axi_awaddr = 0;
    s_axi_araddr = 0;
    s_axi_wdata = 0;
    s_axi_wstrb = 4'hf;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    s_defaults();
    s_mirror();
    s_lut();
    s_exposure();
    s_timer();
    wrap_up();
  end
endmodule
bind pcm_top pcm_checker #(.LINE_LEN(LINE_LEN)) chk (.*);
`default_nettype wire
